// ==== dv/tb_line_cycle_mode.sv ====
// self-checking bench for the line-cycle mode register block
// assumes the block alone, driven from its ports at the rising clock edge
`timescale 1ns/1ps
module tb_line_cycle_mode
	import line_cycle_pkg::*;
;
	localparam int PW = 24;
	localparam int AW = 32;
	logic                  core_clk_i = 1'b0;
	logic                  reset_n_i = 1'b0;
	logic [ADDR_W-1:0]     addr_i = '0;
	logic [DATA_W-1:0]     wr_data_i = '0;
	logic                  wr_en_i = 1'b0;
	logic                  rd_en_i = 1'b0;
	logic [DATA_W-1:0]     rd_data_o;
	logic                  sample_valid_i = 1'b0;
	logic [NUM_ACC*PW-1:0] power_i = '0;
	logic [NUM_PHASES-1:0] zero_cross_i = '0;
	logic                  period_end_o;
	logic                  pf_update_o;
	logic [NUM_PHASES*AW-1:0] pf_num_o;
	logic [NUM_PHASES*AW-1:0] pf_den_o;
	int n_fail = 0;
	int checked = 0;
	int cyc = 0;
	logic [31:0] d;
	line_cycle_mode #(.PW(PW), .AW(AW)) line_cycle_mode_i (
		.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
		.wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
		.rd_data_o(rd_data_o), .sample_valid_i(sample_valid_i),
		.power_i(power_i), .zero_cross_i(zero_cross_i),
		.period_end_o(period_end_o), .pf_update_o(pf_update_o),
		.pf_num_o(pf_num_o), .pf_den_o(pf_den_o));
	always #2 core_clk_i = ~core_clk_i;
	// ==========================================================
	// shared tasks
	task results;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : results
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [15:0] a, input logic [31:0] v);
		@(posedge core_clk_i);
		wr_en_i   <= 1'b1;
		addr_i    <= a;
		wr_data_i <= v;
		@(posedge core_clk_i);
		wr_en_i <= 1'b0;
	endtask : wr
	task rd(input logic [15:0] a, output logic [31:0] v);
		@(posedge core_clk_i);
		rd_en_i <= 1'b1;
		addr_i  <= a;
		@(posedge core_clk_i);
		rd_en_i <= 1'b0;
		#1 v = rd_data_o;
	endtask : rd
	task samp;
		@(posedge core_clk_i);
		sample_valid_i <= 1'b1;
		@(posedge core_clk_i);
		sample_valid_i <= 1'b0;
	endtask : samp
	// pulse zero-cross bits, judge the period end in that cycle
	task zx(input logic [2:0] b, input logic e);
		@(posedge core_clk_i);
		zero_cross_i <= b;
		#1 chk({31'h0, period_end_o}, {31'h0, e});
		@(posedge core_clk_i);
		zero_cross_i <= '0;
	endtask : zx
	// ==========================================================
	// scenarios
	task t_reset;
		rd(CFG_ADDR, d);
		chk(d, 32'h0000_0078);
		rd(HCC_ADDR, d);
		chk(d, 32'h0000_00FF);
		rd(16'h0000, d);
		chk(d, 32'h0000_0000);
		$display("reset test done");
	endtask : t_reset
	task t_read_clear;
		samp();
		samp();
		for (int i = 0; i < NUM_ACC; i++) begin
			rd(ACC_BASE + 16'(i), d);
			chk(d, 32'(2 * (i + 1)));
			rd(ACC_BASE + 16'(i), d);
			chk(d, 32'h0000_0000);
		end
		$display("read clear test done");
	endtask : t_read_clear
	task t_no_clear;
		wr(CFG_ADDR, 32'h0000_0038);
		samp();
		rd(ACC_BASE + 16'h0002, d);
		chk(d, 32'h0000_0003);
		rd(ACC_BASE + 16'h0002, d);
		chk(d, 32'h0000_0003);
		$display("no clear test done");
	endtask : t_no_clear
	task t_line;
		wr(CFG_ADDR, 32'h0000_000F);
		wr(HCC_ADDR, 32'h0000_0002);
		zx(3'b010, 1'b0);
		zx(3'b001, 1'b0);
		zx(3'b001, 1'b1);
		samp();
		samp();
		samp();
		zx(3'b001, 1'b0);
		zx(3'b001, 1'b1);
		rd(ACC_BASE, d);
		chk(d, 32'h0000_0003);
		rd(ACC_BASE + 16'h0006, d);
		chk(d, 32'h0000_0015);
		rd(ACC_BASE + 16'h000C, d);
		chk(d, 32'h0000_0027);
		samp();
		zx(3'b001, 1'b0);
		zx(3'b001, 1'b1);
		rd(ACC_BASE, d);
		chk(d, 32'h0000_0001);
		$display("line cycle test done");
	endtask : t_line
	task t_multi;
		wr(CFG_ADDR, 32'h0000_003F);
		zx(3'b011, 1'b1);
		zx(3'b111, 1'b1);
		wr(HCC_ADDR, 32'h0000_0003);
		zx(3'b011, 1'b0);
		zx(3'b001, 1'b1);
		$display("multi phase test done");
	endtask : t_multi
	task t_pf_inst;
		wr(CFG_ADDR, 32'h0000_0038);
		samp();
		#1 chk({31'h0, pf_update_o}, 32'h0000_0001);
		chk(pf_num_o[31:0], 32'h0000_0001);
		chk(pf_den_o[63:32], 32'h0000_000E);
		$display("instant pf test done");
	endtask : t_pf_inst
	task t_pf_line;
		wr(CFG_ADDR, 32'h0000_008D);
		wr(HCC_ADDR, 32'h0000_0002);
		zx(3'b001, 1'b0);
		zx(3'b001, 1'b1);
		@(posedge core_clk_i);
		samp();
		samp();
		zx(3'b001, 1'b0);
		zx(3'b001, 1'b1);
		@(posedge core_clk_i);
		#1 chk({31'h0, pf_update_o}, 32'h0000_0001);
		chk(pf_num_o[31:0], 32'h0000_0002);
		chk(pf_den_o[31:0], 32'h0000_001A);
		rd(ACC_BASE + 16'h0006, d);
		chk(d, 32'h0000_0015);
		$display("line pf test done");
	endtask : t_pf_line
	// ==========================================================
	// main sequence and hang guard
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			results();
		end
	end
	initial begin
		for (int i = 0; i < NUM_ACC; i++) power_i[i*PW +: PW] = PW'(i + 1);
		repeat (12) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		t_reset();
		t_read_clear();
		t_no_clear();
		t_line();
		t_multi();
		t_pf_inst();
		t_pf_line();
		results();
	end
endmodule : tb_line_cycle_mode

// ==== src/energy_accum.sv ====
// one energy accumulator with regular and line-cycle modes
// assumes power samples and clear come from the same clock domain
`timescale 1ns/1ps
module energy_accum #(
	parameter int PW = 24,
	parameter int AW = 32
) (
	input  wire logic                 core_clk_i,     // core clock
	input  wire logic                 reset_n_i,      // async reset, low
	input  wire logic                 sample_valid_i, // new power sample
	input  wire logic signed [PW-1:0] power_i,        // power sample
	input  wire logic                 line_mode_i,    // line-cycle mode
	input  wire logic                 period_end_i,   // period boundary
	input  wire logic                 clear_i,        // read with clear
	output logic signed [AW-1:0]      energy_o        // visible energy
);
	logic signed [AW-1:0] running;
	logic signed [AW-1:0] next_running;
	logic signed [AW-1:0] next_energy;
	wire  signed [AW-1:0] add_w = sample_valid_i ?
		{{(AW-PW){power_i[PW-1]}}, power_i} : '0;

	// ==========================================================
	// line mode latches one period then restarts the sum
	assign next_running = !line_mode_i ? '0 :
		period_end_i ? '0 : running + add_w;          // see [R12]
	assign next_energy = line_mode_i ?
		(period_end_i ? running + add_w :
		 (clear_i ? '0 : energy_o)) :                  // see [R12]
		(clear_i ? add_w : energy_o + add_w);        // see [R6]

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			running  <= '0;
			energy_o <= '0;
		end else begin
			running  <= next_running;
			energy_o <= next_energy;
		end
	end

	// ==========================================================
	// checks
	a_regular_sums: assert property (@(posedge core_clk_i) // see [R1]
		disable iff (!reset_n_i)
		!line_mode_i && sample_valid_i && !clear_i |=>
		energy_o == $past(energy_o) + $past(add_w))
		else $error("regular accumulation lost a sample");
	a_line_holds: assert property (@(posedge core_clk_i) // see [R12]
		disable iff (!reset_n_i)
		line_mode_i && !period_end_i && !clear_i |=>
		$stable(energy_o))
		else $error("line mode value moved inside period");
	a_clear_zero: assert property (@(posedge core_clk_i) // see [R6]
		disable iff (!reset_n_i)
		clear_i && !sample_valid_i && !period_end_i |=> energy_o == 0)
		else $error("read with clear left a value");
endmodule : energy_accum

// ==== src/line_cycle_mode.sv ====
// line-cycle mode register and the energy accumulators it steers
// assumes samples and zero-cross pulses come from core clock logic
//
// How it works
// [R1] bit 0 selects line mode for active
// [R2] bit 1 selects line mode for reactive
// [R3] bit 2 selects line mode for apparent
// [R4] bits 3-5 select phases for zero-cross count
// [R5] selected phases count crossings together
// [R6] bit 6 set: reading clears accumulator
// [R7] bit 6 clear: reading leaves accumulator unchanged
// [R8] software clears bit 6 when all modes line
// [R9] bit 7 clear: power factor from instantaneous powers
// [R10] bit 7 set: power factor per line period
// [R11] software sets bits 0 and 2 first
// [R12] line mode latches one period, then restarts
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module line_cycle_mode
	import line_cycle_pkg::*;
#(
	parameter int PW = 24,
	parameter int AW = 32
) (
	input  wire logic                    core_clk_i,     // core clock
	input  wire logic                    reset_n_i,      // async reset, low
	input  wire logic [ADDR_W-1:0]       addr_i,         // register address
	input  wire logic [DATA_W-1:0]       wr_data_i,      // write data
	input  wire logic                    wr_en_i,        // write strobe
	input  wire logic                    rd_en_i,        // read strobe
	output logic [DATA_W-1:0]            rd_data_o,      // read data
	input  wire logic                    sample_valid_i, // power sample strobe
	input  wire logic [NUM_ACC*PW-1:0]   power_i,        // powers by index
	input  wire logic [NUM_PHASES-1:0]   zero_cross_i,   // zero-cross pulses
	output logic                         period_end_o,   // line period done
	output logic                         pf_update_o,    // pf operands new
	output logic [NUM_PHASES*AW-1:0]     pf_num_o,       // pf active operand
	output logic [NUM_PHASES*AW-1:0]     pf_den_o        // pf apparent operand
);
	logic [7:0]              line_cycle_mode_config;
	logic [15:0]             half_cycle_count;
	logic [15:0]             zc_count;
	logic                    period_end_q;
	logic [NUM_ACC*AW-1:0]   energy_flat;
	logic [NUM_ACC-1:0]      clear_vec;
	logic [NUM_KINDS-1:0]    kind_line;
	logic [DATA_W-1:0]       next_rd_data;

	// ==========================================================
	// field decode
	wire       active_line_cycle_enable   =
		line_cycle_mode_config[ACTIVE_BIT];
	wire       reactive_line_cycle_enable =
		line_cycle_mode_config[REACTIVE_BIT];
	wire       apparent_line_cycle_enable =
		line_cycle_mode_config[APPARENT_BIT];
	wire [2:0] zero_cross_phase_select    =
		line_cycle_mode_config[ZX_SEL_LSB +: NUM_PHASES];
	wire       read_clear_enable          =
		line_cycle_mode_config[READ_CLR_BIT];
	wire       power_factor_source        =
		line_cycle_mode_config[PF_SRC_BIT];

	assign kind_line[KIND_ACTIVE]   = active_line_cycle_enable;   // see [R1]
	assign kind_line[KIND_FACTIVE]  = active_line_cycle_enable;   // see [R1]
	assign kind_line[KIND_REACTIVE] = reactive_line_cycle_enable; // see [R2]
	assign kind_line[KIND_FREACT]   = reactive_line_cycle_enable; // see [R2]
	assign kind_line[KIND_APPARENT] = apparent_line_cycle_enable; // see [R3]

	// ==========================================================
	// address decode
	wire        cfg_hit = (addr_i == CFG_ADDR);
	wire        hcc_hit = (addr_i == HCC_ADDR);
	wire [15:0] acc_off = addr_i - ACC_BASE;
	wire        acc_hit = (addr_i >= ACC_BASE) &&
		(acc_off < 16'(NUM_ACC));
	wire [3:0]  acc_idx = acc_off[3:0];
	wire        acc_read = rd_en_i && acc_hit;
	wire [AW-1:0] acc_val = energy_flat[acc_idx*AW +: AW];

	assign next_rd_data = cfg_hit ? {24'h000000, line_cycle_mode_config} :
		hcc_hit ? {16'h0000, half_cycle_count} :
		acc_hit ? DATA_W'(acc_val) : '0;

	// ==========================================================
	// zero-cross counting over the selected phases
	wire [2:0]  zx_hits = zero_cross_i & zero_cross_phase_select; // see [R4]
	wire [1:0]  zx_add  = 2'(zx_hits[0]) + 2'(zx_hits[1]) +
		2'(zx_hits[2]);                                  // see [R5]
	wire [15:0] zc_next = zc_count + 16'(zx_add);
	assign period_end_o = (zx_add != 2'b00) &&
		(zc_next >= half_cycle_count);                   // see [R5]

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			line_cycle_mode_config <= CFG_RESET;
			half_cycle_count       <= HCC_RESET;
			rd_data_o              <= '0;
			zc_count               <= '0;
			period_end_q           <= 1'b0;
		end else begin
			if (wr_en_i && cfg_hit)
				line_cycle_mode_config <= wr_data_i[7:0];
			if (wr_en_i && hcc_hit)
				half_cycle_count <= wr_data_i[15:0];
			if (rd_en_i)
				rd_data_o <= next_rd_data;
			zc_count     <= period_end_o ? '0 : zc_next;  // see [R12]
			period_end_q <= period_end_o;
		end
	end

	// ==========================================================
	// accumulators
	genvar k;
	generate
		for (k = 0; k < NUM_ACC; k++) begin : g_acc
			assign clear_vec[k] = acc_read && read_clear_enable &&
				(acc_idx == 4'(k));                  // see [R6] [R7]
			energy_accum #(.PW(PW), .AW(AW)) u_acc (
				.core_clk_i     (core_clk_i),
				.reset_n_i      (reset_n_i),
				.sample_valid_i (sample_valid_i),
				.power_i        (power_i[k*PW +: PW]),
				.line_mode_i    (kind_line[k/NUM_PHASES]),
				.period_end_i   (period_end_o),
				.clear_i        (clear_vec[k]),
				.energy_o       (energy_flat[k*AW +: AW])
			);
		end
	endgenerate

	// ==========================================================
	// power factor operands
	genvar p;
	generate
		for (p = 0; p < NUM_PHASES; p++) begin : g_pf
			localparam int AI = KIND_ACTIVE * NUM_PHASES + p;
			localparam int SI = KIND_APPARENT * NUM_PHASES + p;
			wire [PW-1:0] act_pw = power_i[AI*PW +: PW];
			wire [PW-1:0] app_pw = power_i[SI*PW +: PW];
			always_ff @(posedge core_clk_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					pf_num_o[p*AW +: AW] <= '0;
					pf_den_o[p*AW +: AW] <= '0;
				end else if (power_factor_source && period_end_q) begin
					pf_num_o[p*AW +: AW] <=
						energy_flat[AI*AW +: AW];     // see [R10]
					pf_den_o[p*AW +: AW] <=
						energy_flat[SI*AW +: AW];     // see [R10]
				end else if (!power_factor_source && sample_valid_i) begin
					pf_num_o[p*AW +: AW] <=
						{{(AW-PW){act_pw[PW-1]}}, act_pw}; // see [R9]
					pf_den_o[p*AW +: AW] <=
						{{(AW-PW){app_pw[PW-1]}}, app_pw}; // see [R9]
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			pf_update_o <= 1'b0;
		else
			pf_update_o <= power_factor_source ? period_end_q :
				sample_valid_i;                          // see [R9] [R10]
	end

	// ==========================================================
	// checks
	a_no_read_clear: assert property (@(posedge core_clk_i) // see [R7]
		disable iff (!reset_n_i)
		!read_clear_enable |-> clear_vec == '0)
		else $error("accumulator cleared with read clear off");
	a_zx_excluded: assert property (@(posedge core_clk_i) // see [R4]
		disable iff (!reset_n_i)
		(zero_cross_i & zero_cross_phase_select) == 3'b000 |->
		!period_end_o ##1 $stable(zc_count))
		else $error("unselected phase counted");
	a_period_restart: assert property (@(posedge core_clk_i) // see [R12]
		disable iff (!reset_n_i)
		period_end_o |=> zc_count == 16'h0000)
		else $error("count not restarted after period");
	a_pf_instant: assert property (@(posedge core_clk_i) // see [R9]
		disable iff (!reset_n_i)
		!power_factor_source && sample_valid_i |=>
		pf_update_o && pf_num_o[AW-1:0] ==
		{{(AW-PW){$past(power_i[PW-1])}}, $past(power_i[PW-1:0])})
		else $error("instantaneous pf operand wrong");
	a_pf_line_rate: assert property (@(posedge core_clk_i) // see [R10]
		disable iff (!reset_n_i)
		power_factor_source && !period_end_o ##1
		power_factor_source |=> !pf_update_o ##1 1'b1)
		else $error("line pf updated outside period end");
endmodule : line_cycle_mode

// ==== src/line_cycle_pkg.sv ====
// constants of the energy accumulator mode block
// assumes one 250 MHz core clock and a strobe-style register port
package line_cycle_pkg;
	localparam int          NUM_PHASES    = 3;
	localparam int          NUM_KINDS     = 5;
	localparam int          NUM_ACC       = NUM_PHASES * NUM_KINDS;
	localparam int          ADDR_W        = 16;
	localparam int          DATA_W        = 32;
	// ==========================================================
	// register map
	localparam logic [15:0] CFG_ADDR      = 16'hE702;
	localparam logic [15:0] HCC_ADDR      = 16'hE60C;
	localparam logic [15:0] ACC_BASE      = 16'hE400;
	localparam logic [7:0]  CFG_RESET     = 8'h78;
	localparam logic [15:0] HCC_RESET     = 16'h00FF;
	// ==========================================================
	// config field positions
	localparam int          ACTIVE_BIT    = 0;
	localparam int          REACTIVE_BIT  = 1;
	localparam int          APPARENT_BIT  = 2;
	localparam int          ZX_SEL_LSB    = 3;
	localparam int          READ_CLR_BIT  = 6;
	localparam int          PF_SRC_BIT    = 7;
	// ==========================================================
	// accumulator kinds, index = kind * NUM_PHASES + phase
	localparam int          KIND_ACTIVE   = 0;
	localparam int          KIND_FACTIVE  = 1;
	localparam int          KIND_REACTIVE = 2;
	localparam int          KIND_FREACT   = 3;
	localparam int          KIND_APPARENT = 4;
endpackage : line_cycle_pkg
